// ---- include/sfbc_pkg.sv ----
package sfbc_pkg;

  // Register port geometry.
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned DATA_W         = 16;

  // Register offsets.
  localparam logic [3:0]  REG_COUNT      = 4'h0;
  localparam logic [3:0]  REG_FCTRL      = 4'h1;
  localparam logic [3:0]  REG_SCTRL      = 4'h2;
  localparam logic [3:0]  REG_STATUS     = 4'h3;
  localparam logic [3:0]  REG_DATA       = 4'h4;

  // Count register byte lanes: FIFO 1 low, FIFO 2 high.
  localparam int unsigned CNT1_LSB       = 0;
  localparam int unsigned CNT2_LSB       = 8;

  // FIFO control register fields.
  localparam int unsigned FC_FE1         = 0;
  localparam int unsigned FC_FE2         = 1;
  localparam int unsigned FC_RESET1      = 2;
  localparam int unsigned FC_RESET2      = 3;
  localparam int unsigned FC_SEL         = 4;
  localparam int unsigned FC_IDLE_EN     = 5;
  localparam int unsigned FC_REQ         = 6;

  // Serial control register fields.
  localparam int unsigned SC_RXE         = 0;
  localparam int unsigned SC_TXE         = 1;
  localparam int unsigned SC_TIE         = 2;
  localparam int unsigned SC_TX_IDLE_IRQ_ENABLE        = 3;

  // Status register fields.
  localparam int unsigned ST_RX_FULL     = 0;
  localparam int unsigned ST_TX_EMPTY    = 1;
  localparam int unsigned ST_MRX_BUSY    = 2;

  // Reset values and limits.
  localparam logic [7:0]  THR_RESET      = 8'h08;
  localparam logic [3:0]  IDLE_TICKS     = 4'h8;
  localparam int unsigned FIFO_DEPTH_MAX = 128;
  localparam int unsigned ENTRY_W        = 9;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sfbc_req_s;

  typedef struct packed {
    logic               valid;
    logic [ENTRY_W-1:0] data;
  } sfbc_byte_s;

endpackage : sfbc_pkg

// ---- hdl/sfbc_top.sv ----
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module sfbc_top #(
  parameter int unsigned DEPTH = sfbc_pkg::FIFO_DEPTH_MAX
) (
  input  wire logic                                clk_sys,
  input  wire logic                                rst,
  input  wire sfbc_pkg::sfbc_req_s                 bus_req,
  output logic [sfbc_pkg::DATA_W-1:0]              bus_rdata,
  input  wire sfbc_pkg::sfbc_byte_s                rx_byte,
  output sfbc_pkg::sfbc_byte_s                     tx_byte,
  input  wire logic                                tx_taken,
  input  wire logic                                baud_tick,
  output logic                                     mrx_clk_req,
  input  wire logic                                mrx_byte_done,
  output logic                                     rx_full_flag,
  output logic                                     tx_fifo_request_flag
);
  import sfbc_pkg::*;

  localparam int unsigned PTR_W   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [7:0]  DEPTH_C = 8'(DEPTH);

  typedef logic [PTR_W-1:0] sfbc_ptr_t;

  function automatic logic [7:0] sfbc_count_step(input logic [7:0] c,
                                                 input logic clr,
                                                 input logic push,
                                                 input logic pop);
    logic [7:0] r;
    r = c;
    if (clr) begin
      r = 8'h00;
    end else if (push && !pop) begin
      r = 8'(c + 8'h01);
    end else if (pop && !push) begin
      r = 8'(c - 8'h01);
    end
    return r;
  endfunction : sfbc_count_step

  function automatic sfbc_ptr_t sfbc_ptr_step(input sfbc_ptr_t p);
    return (32'(p) == DEPTH - 1) ? '0 : PTR_W'(p + 1'b1);
  endfunction : sfbc_ptr_step

  // Index 0 is FIFO 1, index 1 is FIFO 2.
  logic [ENTRY_W-1:0] mem       [2][DEPTH];
  logic [7:0]         cnt       [2];
  logic [7:0]         thr       [2];
  sfbc_ptr_t          wptr      [2];
  sfbc_ptr_t          rptr      [2];
  logic [1:0]         fe;
  logic               sel;
  logic               idle_en;
  logic               rx_enable;
  logic               tx_enable;
  logic               tx_empty_irq_enable;
  logic               tx_idle_irq_enable;
  logic [3:0]         idle_cnt;
  logic [7:0]         mrx_left;
  logic               req_lvl_q;

  // Address decode.
  wire wr_count  = bus_req.wr && (bus_req.addr == REG_COUNT);
  wire wr_fctrl  = bus_req.wr && (bus_req.addr == REG_FCTRL);
  wire wr_sctrl  = bus_req.wr && (bus_req.addr == REG_SCTRL);
  wire wr_data   = bus_req.wr && (bus_req.addr == REG_DATA);
  wire rd_data   = bus_req.rd && (bus_req.addr == REG_DATA);

  // Role selection.
  wire        rx_idx = ~sel;
  wire        tx_idx = sel;
  wire [7:0]  rx_cnt = cnt[rx_idx];
  wire [7:0]  rx_thr = thr[rx_idx];
  wire [7:0]  tx_cnt = cnt[tx_idx];
  wire        mrx_busy = (mrx_left != 8'h00);

  wire rx_push = rx_byte.valid && rx_enable && fe[rx_idx] && (rx_cnt < DEPTH_C);
  wire rx_pop  = rd_data && (rx_cnt != 8'h00);
  wire tx_push = wr_data && fe[tx_idx] && (tx_cnt < DEPTH_C);
  wire tx_go   = fe[tx_idx] && tx_enable && (tx_cnt != 8'h00) && !mrx_busy;
  wire tx_pop  = tx_go && tx_taken;

  // Bit 1 of each vector belongs to FIFO 2.
  wire [1:0] push = rx_idx ? {rx_push, tx_push} : {tx_push, rx_push};
  wire [1:0] pop  = rx_idx ? {rx_pop, tx_pop} : {tx_pop, rx_pop};
  wire [1:0] clr  = {wr_fctrl && bus_req.wdata[FC_RESET2],
                     wr_fctrl && bus_req.wdata[FC_RESET1]};

  wire [7:0] next_cnt1 = sfbc_count_step(cnt[0], clr[0], push[0], pop[0]);
  wire [7:0] next_cnt2 = sfbc_count_step(cnt[1], clr[1], push[1], pop[1]);

  wire [ENTRY_W-1:0] push_data = rx_idx ? (push[1] ? rx_byte.data
                                                   : bus_req.wdata[8:0])
                                        : (push[1] ? bus_req.wdata[8:0]
                                                   : rx_byte.data);

  // FIFO storage and pointers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        wptr[i] <= '0;
        rptr[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (clr[i]) begin
          wptr[i] <= '0;
          rptr[i] <= '0;
        end else begin
          if (push[i]) begin
            wptr[i] <= sfbc_ptr_step(wptr[i]);
          end
          if (pop[i]) begin
            rptr[i] <= sfbc_ptr_step(rptr[i]);
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (push[i] && !clr[i]) begin
        mem[i][wptr[i]] <= push_data;
      end
    end
  end

  // Live counts and thresholds; a count-register write only touches thresholds.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt[0] <= 8'h00;
      cnt[1] <= 8'h00;
      thr[0] <= THR_RESET;
      thr[1] <= THR_RESET;
    end else begin
      cnt[0] <= next_cnt1;
      cnt[1] <= next_cnt2;
      if (wr_count) begin
        thr[0] <= bus_req.wdata[CNT1_LSB +: 8];
        thr[1] <= bus_req.wdata[CNT2_LSB +: 8];
      end
    end
  end

  // Control registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fe      <= 2'h0;
      sel     <= 1'b0;
      idle_en <= 1'b0;
      rx_enable     <= 1'b0;
      tx_enable     <= 1'b0;
      tx_empty_irq_enable     <= 1'b0;
      tx_idle_irq_enable    <= 1'b0;
    end else begin
      if (wr_fctrl) begin
        fe      <= {bus_req.wdata[FC_FE2], bus_req.wdata[FC_FE1]};
        sel     <= bus_req.wdata[FC_SEL];
        idle_en <= bus_req.wdata[FC_IDLE_EN];
      end
      if (wr_sctrl) begin
        rx_enable  <= bus_req.wdata[SC_RXE];
        tx_enable  <= bus_req.wdata[SC_TXE];
        tx_empty_irq_enable  <= bus_req.wdata[SC_TIE];
        tx_idle_irq_enable <= bus_req.wdata[SC_TX_IDLE_IRQ_ENABLE];
      end
    end
  end

  // Receive idle timeout.
  wire idle_run  = rx_enable && fe[rx_idx] && idle_en && !rx_full_flag &&
                   (rx_cnt != 8'h00) && (rx_cnt < rx_thr);
  wire idle_hit  = idle_run && baud_tick && (idle_cnt == IDLE_TICKS);
  wire idle_zero = !fe[rx_idx] || rd_data || rx_push;
  logic [3:0] next_idle_cnt;
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (idle_zero) begin
      next_idle_cnt = 4'h0;
    end else if (idle_run && baud_tick && !idle_hit) begin
      next_idle_cnt = 4'(idle_cnt + 4'h1);
    end
  end

  // The flag sets on the level match or the timeout; a set beats a clear.
  wire level_hit = (rx_cnt == rx_thr) && (rx_cnt != 8'h00);
  wire next_full = (level_hit || idle_hit) ? 1'b1 :
                   (rx_cnt == 8'h00) ? 1'b0 : rx_full_flag;
  // Master reception: the transmit threshold sets the byte clock budget.
  wire mrx_load = wr_sctrl && bus_req.wdata[SC_TXE] && !tx_enable &&
                  bus_req.wdata[SC_RXE] && fe[tx_idx] &&
                  (thr[tx_idx] != 8'h00);

  logic [7:0] next_mrx_left;
  always_comb begin
    next_mrx_left = mrx_left;
    if (mrx_load) begin
      next_mrx_left = thr[tx_idx];
    end else if (!fe[tx_idx] || !tx_enable) begin
      next_mrx_left = 8'h00;
    end else if (mrx_byte_done && mrx_busy) begin
      next_mrx_left = 8'(mrx_left - 8'h01);
    end
  end

  wire req_lvl = fe[tx_idx] && (tx_cnt == 8'h00) && !mrx_busy;
  wire req_set = req_lvl && !req_lvl_q;
  wire req_clr = wr_fctrl && !bus_req.wdata[FC_REQ];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_lvl_q            <= 1'b0;
      idle_cnt             <= 4'h0;
      rx_full_flag         <= 1'b0;
      mrx_left             <= 8'h00;
      tx_fifo_request_flag <= 1'b0;
    end else begin
      idle_cnt             <= next_idle_cnt;
      rx_full_flag         <= next_full;
      mrx_left             <= next_mrx_left;
      req_lvl_q            <= req_lvl;
      tx_fifo_request_flag <= req_set | (tx_fifo_request_flag & ~req_clr);
    end
  end

  assign mrx_clk_req  = mrx_busy && tx_enable;
  assign tx_byte.valid = tx_go;
  assign tx_byte.data  = mem[tx_idx][rptr[tx_idx]];

  // Read multiplexer; read data stand only in the cycle after the strobe.
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    case (bus_req.addr)
      REG_COUNT:  next_rdata = {cnt[1], cnt[0]};
      REG_FCTRL: begin
        next_rdata[FC_FE1]     = fe[0];
        next_rdata[FC_FE2]     = fe[1];
        next_rdata[FC_SEL]     = sel;
        next_rdata[FC_IDLE_EN] = idle_en;
        next_rdata[FC_REQ]     = tx_fifo_request_flag;
      end
      REG_SCTRL: begin
        next_rdata[SC_RXE]  = rx_enable;
        next_rdata[SC_TXE]  = tx_enable;
        next_rdata[SC_TIE]  = tx_empty_irq_enable;
        next_rdata[SC_TX_IDLE_IRQ_ENABLE] = tx_idle_irq_enable;
      end
      REG_STATUS: begin
        next_rdata[ST_RX_FULL]  = rx_full_flag;
        next_rdata[ST_TX_EMPTY] = (tx_cnt == 8'h00);
        next_rdata[ST_MRX_BUSY] = mrx_busy;
      end
      REG_DATA:   next_rdata = {7'h00, mem[rx_idx][rptr[rx_idx]]};
      default:    next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= bus_req.rd ? next_rdata : '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_COUNT_LAYOUT: assert property (
    bus_req.rd && bus_req.addr == REG_COUNT |=>
      bus_rdata == {$past(cnt[1]), $past(cnt[0])})
    else $error("count read does not show FIFO 2 high, FIFO 1 low");
  AST_RX_ROLE: assert property (
    rx_push && !rx_pop && clr == 2'h0 |=>
      cnt[$past(rx_idx)] == 8'($past(rx_cnt) + 8'h01))
    else $error("received byte not counted in the selected FIFO");
  AST_THR_WRITE: assert property (
    wr_count |=> thr[0] == $past(bus_req.wdata[7:0]) &&
                 thr[1] == $past(bus_req.wdata[15:8]) &&
                 cnt[0] == $past(next_cnt1))
    else $error("count write did not load thresholds only");
  AST_LEVEL_FULL: assert property (
    level_hit |=> rx_full_flag)
    else $error("threshold match did not set receive-full flag");
  AST_IDLE_FULL: assert property (
    idle_run && baud_tick && idle_cnt == IDLE_TICKS |=> rx_full_flag)
    else $error("idle timeout did not set receive-full flag");
  AST_IDLE_RESTART: assert property (
    rd_data |=> idle_cnt == 4'h0)
    else $error("data read did not clear idle counter");
  AST_IDLE_DISABLE: assert property (
    !fe[rx_idx] |=> idle_cnt == 4'h0)
    else $error("disabled receive FIFO kept idle count");
  AST_MRX_STEP: assert property (
    mrx_byte_done && mrx_busy && tx_enable && fe[tx_idx] && !mrx_load |=>
      mrx_left == 8'($past(mrx_left) - 8'h01))
    else $error("master reception byte budget did not step");
  AST_DEPTH: assert property (
    cnt[0] <= DEPTH_C && cnt[1] <= DEPTH_C)
    else $error("FIFO count above depth");
  AST_FIFO_RESET: assert property (
    clr[0] ##1 !clr[0] [*2] |-> ##0 cnt[0] <= 8'h01)
    else $error("FIFO 1 reset did not clear its count");
  AST_FULL_HOLD: assert property (
    rx_full_flag && rx_cnt != 8'h00 |=> rx_full_flag)
    else $error("receive-full flag dropped with data left");
  AST_IDLE_STOP: assert property (
    rx_full_flag && !idle_zero |=> $stable(idle_cnt))
    else $error("idle counter ran while receive-full flag set");

  COV_LEVEL_FULL: cover property (!rx_full_flag ##1 level_hit);
  COV_IDLE_FULL:  cover property (idle_hit);
  COV_MRX_DONE:   cover property (mrx_busy ##1 !mrx_busy && tx_enable);
  COV_FIFO_FULL:  cover property (rx_cnt == DEPTH_C);

endmodule : sfbc_top

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import sfbc_pkg::*;

  localparam int unsigned TB_DEPTH = 8;
  localparam int unsigned CYC_MAX  = 5000;

  logic                    clk_sys;
  logic                    rst;
  sfbc_req_s               bus_req;
  logic [DATA_W-1:0]       bus_rdata;
  sfbc_byte_s              rx_byte;
  sfbc_byte_s              tx_byte;
  logic                    tx_taken;
  logic                    baud_tick;
  logic                    mrx_clk_req;
  logic                    mrx_byte_done;
  logic                    rx_full_flag;
  logic                    tx_fifo_request_flag;
  int                      miscompares;
  int                      samples_checked;
  int                      cyc;
  logic [15:0]             v;

  sfbc_top #(.DEPTH(TB_DEPTH)) uut (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .bus_req              (bus_req),
    .bus_rdata            (bus_rdata),
    .rx_byte              (rx_byte),
    .tx_byte              (tx_byte),
    .tx_taken             (tx_taken),
    .baud_tick            (baud_tick),
    .mrx_clk_req          (mrx_clk_req),
    .mrx_byte_done        (mrx_byte_done),
    .rx_full_flag         (rx_full_flag),
    .tx_fifo_request_flag (tx_fifo_request_flag)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("Compared %0d values, %0d mismatches", samples_checked,
             miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic cmp(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req.wr    <= 1'b1;
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    @(posedge clk_sys);
    bus_req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk_sys);
    bus_req.rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp,
                        input string name);
    logic [15:0] d;
    rd(a, d);
    cmp(name, exp, d);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic flag_chk(input logic exp);
    idle(2);
    cmp("rx_full_flag", {15'h0, exp}, {15'h0, rx_full_flag});
  endtask : flag_chk

  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_byte <= {1'b1, 9'(i)};
    end
    @(posedge clk_sys);
    rx_byte.valid <= 1'b0;
  endtask : fill

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      baud_tick <= 1'b1;
      @(posedge clk_sys);
      baud_tick <= 1'b0;
    end
  endtask : ticks

  task automatic done_pulse();
    @(posedge clk_sys);
    mrx_byte_done <= 1'b1;
    @(posedge clk_sys);
    mrx_byte_done <= 1'b0;
  endtask : done_pulse

  initial begin
    rst = 1'b1;
    bus_req = '0;
    rx_byte = '0;
    tx_taken = 1'b0;
    baud_tick = 1'b0;
    mrx_byte_done = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Default thresholds of 8, receive FIFO in the high byte.
    rd_chk(REG_COUNT, 16'h0000, "count");
    rd_chk(4'hF, 16'h0000, "unmapped");
    wr(REG_FCTRL, 16'h0003);
    wr(REG_SCTRL, 16'h0001);
    fill(7);
    rd_chk(REG_COUNT, 16'h0700, "count");
    flag_chk(1'b0);
    fill(1);
    flag_chk(1'b1);
    rd_chk(REG_COUNT, 16'h0800, "count");
    // The eighth byte came from a one-byte fill and so carries 0.
    for (int i = 0; i < 8; i++) begin
      rd_chk(REG_DATA, 16'(i % 7), "rx data");
      if (i == 6) flag_chk(1'b1);
    end
    flag_chk(1'b0);
    $display("test defaults done");
    // A count write sets the threshold and leaves the live count alone.
    wr(REG_SCTRL, 16'h0000);
    wr(REG_COUNT, 16'h0200);
    wr(REG_SCTRL, 16'h0001);
    rd_chk(REG_COUNT, 16'h0000, "count");
    fill(2);
    flag_chk(1'b1);
    rd_chk(REG_COUNT, 16'h0200, "count");
    repeat (2) rd(REG_DATA, v);
    $display("test threshold done");
    // Swapped roles: FIFO 1 receives and reports in the low byte.
    wr(REG_SCTRL, 16'h0000);
    wr(REG_FCTRL, 16'h0013);
    wr(REG_COUNT, 16'h0002);
    wr(REG_SCTRL, 16'h0001);
    fill(1);
    rd_chk(REG_COUNT, 16'h0001, "count");
    flag_chk(1'b0);
    wr(REG_FCTRL, 16'h0017);
    rd_chk(REG_COUNT, 16'h0000, "count");
    $display("test swap done");
    // Idle timeout with restart by data read and by FIFO disable.
    wr(REG_SCTRL, 16'h0000);
    wr(REG_FCTRL, 16'h0023);
    wr(REG_COUNT, 16'h0800);
    wr(REG_SCTRL, 16'h0001);
    fill(2);
    ticks(5);
    rd(REG_DATA, v);
    ticks(8);
    flag_chk(1'b0);
    wr(REG_FCTRL, 16'h0021);
    wr(REG_FCTRL, 16'h0023);
    ticks(8);
    flag_chk(1'b0);
    ticks(1);
    flag_chk(1'b1);
    rd(REG_DATA, v);
    flag_chk(1'b0);
    $display("test idle done");
    // Transmit path through FIFO 1.
    wr(REG_SCTRL, 16'h0000);
    wr(REG_FCTRL, 16'h0003);
    wr(REG_DATA, 16'h01A5);
    rd_chk(REG_COUNT, 16'h0001, "count");
    wr(REG_SCTRL, 16'h0002);
    idle(1);
    cmp("tx valid", 16'h0001, {15'h0, tx_byte.valid});
    cmp("tx data", 16'h01A5, {7'h0, tx_byte.data});
    @(posedge clk_sys);
    tx_taken <= 1'b1;
    @(posedge clk_sys);
    tx_taken <= 1'b0;
    idle(2);
    cmp("tx valid", 16'h0000, {15'h0, tx_byte.valid});
    rd_chk(REG_COUNT, 16'h0000, "count");
    $display("test transmit done");
    // Master reception of exactly two bytes.
    wr(REG_SCTRL, 16'h0000);
    wr(REG_COUNT, 16'h0802);
    wr(REG_FCTRL, 16'h0003);
    idle(1);
    cmp("request flag", 16'h0000, {15'h0, tx_fifo_request_flag});
    wr(REG_SCTRL, 16'h0001);
    wr(REG_SCTRL, 16'h0003);
    idle(1);
    cmp("mrx clk req", 16'h0001, {15'h0, mrx_clk_req});
    rd_chk(REG_STATUS, 16'h0006, "status");
    done_pulse();
    idle(1);
    cmp("mrx clk req", 16'h0001, {15'h0, mrx_clk_req});
    cmp("request flag", 16'h0000, {15'h0, tx_fifo_request_flag});
    done_pulse();
    idle(2);
    cmp("mrx clk req", 16'h0000, {15'h0, mrx_clk_req});
    cmp("request flag", 16'h0001, {15'h0, tx_fifo_request_flag});
    wr(REG_SCTRL, 16'h000F);
    rd_chk(REG_SCTRL, 16'h000F, "serial control");
    wr(REG_FCTRL, 16'h0002);
    wr(REG_SCTRL, 16'h0000);
    wr(REG_COUNT, 16'h0800);
    rd_chk(REG_FCTRL, 16'h0002, "fifo control");
    cmp("mrx clk req", 16'h0000, {15'h0, mrx_clk_req});
    $display("test master rx done");
    print_verdict();
  end
endmodule : tb
